/* hw/lid_pkg.sv */
package lid_pkg;
    // Network families as reported by the module core
    localparam logic [1:0] NET_OTHER = 2'h0;
    localparam logic [1:0] NET_ETH = 2'h1;
    localparam logic [1:0] NET_ETH_IP = 2'h2;
    // Link speed codes
    localparam logic [1:0] SPD_NONE = 2'h0;
    localparam logic [1:0] SPD_10 = 2'h1;
    localparam logic [1:0] SPD_100 = 2'h2;
    localparam logic [1:0] SPD_1000 = 2'h3;
    // Clock and flicker timing
    localparam int CLK_HZ = 20000000;
    localparam int FLICKER_MS = 50;
    localparam int FLICKER_CYCLES = CLK_HZ / 1000 * FLICKER_MS;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;
    localparam logic LED_RESET = 1'h0;
endpackage

/* hw/lid_led_indicator_driver.sv */
// Notes on behaviour
// - Four bicolour indicators, network status and module status first.
// - Every output is active high, one lights the LED.
// - Port A green shows link and activity on Ethernet, else dark.
// - Port B green shows link and activity on Ethernet, else dark.
// - Port reds show 10 Mbit link and activity on the IP protocols.
// - In speed mode, both outputs low means link off.
// - In speed mode, 10 Mbit lights red only and flickers on activity.
// - In speed mode, 100 Mbit lights green only and flickers.
// - In speed mode, 1 Gbit lights both and they flicker together.
`timescale 1ns/1ns
module lid_led_indicator_driver
    import lid_pkg::*;
#(
    parameter int FlickerCycles = FLICKER_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,

    // Core status
    input wire logic [1:0] netType,
    input wire logic speedMode,
    input wire logic netStatusGreen,
    input wire logic netStatusRed,
    input wire logic moduleStatusGreen,
    input wire logic moduleStatusRed,

    // Port state, same clock
    input wire logic [1:0] portASpeed,
    input wire logic portAActivity,
    input wire logic [1:0] portBSpeed,
    input wire logic portBActivity,

    // Indicator pins
    output logic net_status_green,
    output logic net_status_red,
    output logic module_status_green,
    output logic module_status_red,
    output logic port_a_link_green,
    output logic port_a_link_red,
    output logic port_b_link_green,
    output logic port_b_link_red
);

////////////////////////////////////////////////////////////////////////////////

// Network family decode
// Decoded once, shared by both ports
logic isEth;
logic isIp;

always_comb begin
    isEth = 1'b0;
    isIp = 1'b0;
    unique case (netType)
        NET_ETH: begin
            isEth = 1'b1;
        end
        NET_ETH_IP: begin
            isEth = 1'b1;
            isIp = 1'b1;
        end
        // Both remaining codes mean a non-Ethernet network
        default: begin
            isEth = 1'b0;
            isIp = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Port inputs gathered for the per-port loop

logic [1:0] spd [2];
logic [1:0] act;
logic [1:0] flick;
logic [1:0] linkGreen;
logic [1:0] linkRed;

assign spd[0] = portASpeed;
assign spd[1] = portBSpeed;
assign act[0] = portAActivity;
assign act[1] = portBActivity;

////////////////////////////////////////////////////////////////////////////////
// Per-port stretch counter and indicator pair

for (genvar p = 0; p < 2; p++) begin : g_port
    logic [CNT_W-1:0] stretch_q;
    logic [CNT_W-1:0] stretch_d;
    logic green_q;
    logic green_d;
    logic red_q;
    logic red_d;
    logic linkUp;
    logic tenMeg;
    logic lit;

    assign linkUp = (spd[p] != SPD_NONE);
    assign tenMeg = (spd[p] == SPD_10);
    assign flick[p] = (stretch_q != CNT_RESET);
    // Lit unless a stretch is running
    assign lit = !flick[p];

    always_comb begin
        stretch_d = stretch_q;
        // Retrigger only after expiry so steady traffic still blinks
        // Limitation: bursts inside one stretch merge into one blink
        if (act[p] && !flick[p] && linkUp) begin
            stretch_d = CNT_W'(FlickerCycles);
        end else if (flick[p]) begin
            stretch_d = stretch_q - CNT_W'(1);
        end
    end

    always_comb begin
        green_d = LED_RESET;
        red_d = LED_RESET;
        if (speedMode) begin
            unique case (spd[p])
                SPD_NONE: begin
                    green_d = 1'b0;
                    red_d = 1'b0;
                end
                SPD_10: begin
                    green_d = 1'b0;
                    red_d = lit;
                end
                SPD_100: begin
                    green_d = lit;
                    red_d = 1'b0;
                end
                // Both for 1 Gbit, dark together
                SPD_1000: begin
                    green_d = lit;
                    red_d = lit;
                end
            endcase
        end else begin
            if (isEth && linkUp) begin
                green_d = lit;
            end
            // Red on 10 Mbit for IP protocols
            if (isIp && tenMeg) begin
                red_d = lit;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stretch_q <= CNT_RESET;
            green_q <= LED_RESET;
            red_q <= LED_RESET;
        end else begin
            stretch_q <= stretch_d;
            green_q <= green_d;
            red_q <= red_d;
        end
    end

    assign linkGreen[p] = green_q;
    assign linkRed[p] = red_q;
end

////////////////////////////////////////////////////////////////////////////////
// Status indicators, patterns come ready made from the core

logic netGreen_q;
logic netGreen_d;
logic netRed_q;
logic netRed_d;
logic modGreen_q;
logic modGreen_d;
logic modRed_q;
logic modRed_d;

always_comb begin
    netGreen_d = netStatusGreen;
    netRed_d = netStatusRed;
    modGreen_d = moduleStatusGreen;
    modRed_d = moduleStatusRed;
end

// No synchronisers: the core shares this clock
always_ff @(posedge clk) begin
    if (sys_rst) begin
        netGreen_q <= LED_RESET;
        netRed_q <= LED_RESET;
        modGreen_q <= LED_RESET;
        modRed_q <= LED_RESET;
    end else begin
        netGreen_q <= netGreen_d;
        netRed_q <= netRed_d;
        modGreen_q <= modGreen_d;
        modRed_q <= modRed_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin map, every pin straight from a flop

// Status pins
assign net_status_green = netGreen_q;
assign net_status_red = netRed_q;
assign module_status_green = modGreen_q;
assign module_status_red = modRed_q;
// Port pins
assign port_a_link_green = linkGreen[0];
assign port_a_link_red = linkRed[0];
assign port_b_link_green = linkGreen[1];
assign port_b_link_red = linkRed[1];

endmodule

/* verification/lid_led_props.sv */
`timescale 1ns/1ns
module lid_led_props
    import lid_pkg::*;
(
    // Watched ports
    input wire logic clk, sys_rst, speedMode, portAActivity,
    input wire logic [1:0] netType, portASpeed,
    input wire logic netStatusGreen, net_status_green,
    input wire logic port_a_link_green, port_a_link_red,
    input wire logic port_b_link_green, port_b_link_red
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_status_pass: assert property (!$past(sys_rst) |->
        net_status_green == $past(netStatusGreen)) else $error("status");
    a_a_dark: assert property (netType == NET_OTHER && !speedMode
        |=> !port_a_link_green && !port_a_link_red) else $error("a lit");
    a_b_dark: assert property (netType == NET_OTHER && !speedMode
        |=> !port_b_link_green && !port_b_link_red) else $error("b lit");
    a_red_ip: assert property (!speedMode && netType != NET_ETH_IP
        |=> !port_a_link_red) else $error("red on");
    a_spd_off: assert property (speedMode && portASpeed == SPD_NONE
        |=> !port_a_link_green && !port_a_link_red) else $error("off");
    a_spd_ten: assert property (speedMode && portASpeed == SPD_10
        |=> !port_a_link_green) else $error("10M");
    a_spd_hundred: assert property (speedMode && portASpeed == SPD_100
        |=> !port_a_link_red) else $error("100M");
    a_spd_giga: assert property (speedMode && portASpeed == SPD_1000
        |=> port_a_link_green == port_a_link_red) else $error("1G");
    a_flick_dark: assert property (speedMode && portAActivity &&
        portASpeed == SPD_100 && port_a_link_green
        |-> ##[1:3] !port_a_link_green) else $error("no flicker");
    cover property (speedMode && portASpeed == SPD_1000);
    cover property (speedMode && $fell(port_a_link_green));
    cover property (port_a_link_red && !speedMode);
endmodule
bind lid_led_indicator_driver lid_led_props u_props (.*);

/* verification/lid_led_lamp.sv */
`timescale 1ns/1ns
module lid_led_lamp (
    // Drive pins
    input wire logic greenDrive, redDrive,
    // Seen colour, red in bit 1
    output logic [1:0] glow
);
    assign glow = {redDrive, greenDrive};
endmodule

/* verification/lid_led_indicator_driver_bench.sv */
`timescale 1ns/1ns
module lid_led_indicator_driver_bench;
    import lid_pkg::*;
    logic clk = 0, rst = 1, mode = 0, actA = 0;
    logic [3:0] stat = 0;
    logic [1:0] net = 0, spd = 0, glowA, glowB;
    logic [7:0] leds;
    int failCount = 0, testsRun = 0, lowCnt = 0;
    // Row: netType, speedMode, speed, expected {red,green}
    logic [6:0] rows [9] = '{7'h04, 7'h29, 7'h47, 7'h49, 7'h68,
        7'h30, 7'h36, 7'h39, 7'h3f};
    lid_led_indicator_driver #(.FlickerCycles(5)) dut (.clk(clk),
        .sys_rst(rst), .netType(net), .speedMode(mode),
        .netStatusGreen(stat[3]), .netStatusRed(stat[2]),
        .moduleStatusGreen(stat[1]), .moduleStatusRed(stat[0]),
        .portASpeed(spd), .portAActivity(actA), .portBSpeed(spd),
        .portBActivity(actA), .net_status_green(leds[7]),
        .net_status_red(leds[6]), .module_status_green(leds[5]),
        .module_status_red(leds[4]), .port_a_link_green(leds[3]),
        .port_a_link_red(leds[2]), .port_b_link_green(leds[1]),
        .port_b_link_red(leds[0]));
    lid_led_lamp lampA (.greenDrive(leds[3]), .redDrive(leds[2]),
        .glow(glowA));
    lid_led_lamp lampB (.greenDrive(leds[1]), .redDrive(leds[0]),
        .glow(glowB));
    always #25 clk = ~clk;
    task check(input logic [7:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task printVerdict;
        if (failCount == 0 && testsRun > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Drive at one edge, sample after the next
    task drive(input logic [4:0] cfg, input logic [3:0] st);
        @(posedge clk);
        {net, mode, spd} <= cfg;
        stat <= st;
        @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        check(leds, 8'h00);
        rst <= 1'h0;
        foreach (rows[i]) begin
            drive(rows[i][6:2], 4'h0);
            check(8'(glowA), 8'(rows[i][1:0]));
            check(8'(glowB), 8'(rows[i][1:0]));
        end
        drive(5'h00, 4'h9);
        check(leds, 8'h90);
        drive(5'h00, 4'h6);
        check(leds, 8'h60);
        drive(5'h0e, 4'h0);
        @(posedge clk) actA <= 1'h1;
        @(posedge clk) actA <= 1'h0;
        repeat (12) @(negedge clk)
            lowCnt += int'(glowA == 2'h0) + int'(glowB == 2'h0);
        check(8'(lowCnt), 8'h0a);
        drive(5'h0e, 4'hf);
        check(leds, 8'hfa);
        @(posedge clk) rst <= 1'h1;
        @(posedge clk);
        @(negedge clk);
        check(leds, 8'h00);
        @(posedge clk) rst <= 1'h0;
        @(posedge clk);
        @(negedge clk);
        check(leds, 8'hfa);
        printVerdict;
    end
    // Whole run is well under a few hundred cycles
    initial begin
        repeat (2000) @(posedge clk);
        failCount++;
        printVerdict;
    end
endmodule
